/* verilog/ppio_regs.vh */
`ifndef PPIO_REGS_VH
`define PPIO_REGS_VH

// ----------------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------------
`define PPIO_IDX_PB_PIN 6'h16
`define PPIO_IDX_PB_DIR 6'h17
`define PPIO_IDX_PB_LATCH 6'h18
`define PPIO_IDX_PC_PIN 6'h13
`define PPIO_IDX_PC_DIR 6'h14
`define PPIO_IDX_PC_LATCH 6'h15
`define PPIO_IDX_CTRL 6'h20
`define PPIO_IDX_STATUS 6'h21

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define PPIO_RST_PORT 8'h00
`define PPIO_RST_CTRL 4'h0

// ----------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------
`define PPIO_CTRL_SPI_EN 0
`define PPIO_CTRL_SPI_MASTER 1
`define PPIO_CTRL_POWER_DOWN 2
`define PPIO_CTRL_TIMER_TWO_ASYNC 3

// ----------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------
`define PPIO_STAT_SPI_SLAVE_ACTIVE 0
`define PPIO_STAT_CMP_NEG_ROUTED 1
`define PPIO_STAT_CMP_POS_ROUTED 2
`define PPIO_STAT_XTAL_ON_PINS 3

// ----------------------------------------------------------------------
// Second port pin positions.
// ----------------------------------------------------------------------
`define PPIO_PB_SCK 7
`define PPIO_PB_MISO 6
`define PPIO_PB_MOSI 5
`define PPIO_PB_SEL 4
`define PPIO_PB_CMP_NEG 3
`define PPIO_PB_CMP_POS 2
`define PPIO_PB_CNT_ONE 1
`define PPIO_PB_CNT_ZERO 0

`endif

/* verilog/ppio_sync.v */
// ----------------------------------------------------------------------
// Two flip-flop synchroniser for a group of pin inputs.
// ----------------------------------------------------------------------
module ppio_sync #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // ppio_sync

/* verilog/ppio_pin_cell.v */
// ----------------------------------------------------------------------
// One pin driver: direction, output level and pull-up.
// The drive flops clear at once on reset so the pin floats with no clock.
// ----------------------------------------------------------------------
module ppio_pin_cell (
  input wire clk_i,
  input wire rst_i,
  input wire dir_i,
  input wire latch_i,
  input wire force_in_i,
  input wire detach_i,
  output reg pin_o,
  output reg oe_n_o,
  output reg pullup_o
);

  wire next_drive;
  wire next_pullup;

  assign next_drive = dir_i & ~force_in_i & ~detach_i;
  assign next_pullup = latch_i & ~next_drive & ~detach_i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      oe_n_o <= 1'b1;
      pullup_o <= 1'b0;
    end else begin
      pin_o <= latch_i & next_drive;
      oe_n_o <= ~next_drive;
      pullup_o <= next_pullup;
    end
  end

endmodule // ppio_pin_cell

/* verilog/ppio_top.v */
// Decided for this implementation: the Wishbone register port.
`include "ppio_regs.vh"

// Contract
// R01: As SPI slave the clock pin is input; as master its dir bit rules.
// R02: As SPI master the master-in pin is input; as slave its dir bit rules.
// R03: As SPI slave the master-out pin is input; as master its dir bit rules.
// R04: As SPI slave the select pin is input; as master its dir bit rules.
// R05: As slave the SPI is active only while the far master holds select low.
// R06: A pin forced to input by the SPI role keeps its latch-driven pull-up.
// R07: Second-port bits 3 and 2, inputs without pull-up, feed the comparator.
// R08: In power-down sleep both comparator pins lose their input buffers.
// R09: Second-port bits 1 and 0 feed the counter one and zero count sources.
// R10: Every pin input passes a system-clock synchroniser before any use.
// R11: Third port: 8-bit latch, 8-bit direction and a read-only pin sample.
// R12: Reads of the latch give the latch; pin-sample reads give synced pins.
// R13: A third-port pin drives its latch bit when its dir bit is one.
// R14: A third-port pull-up is on only for an input with its latch bit set.
// R15: All port pins tristate as soon as reset asserts, even with no clock.
// R16: With the timer-two async select set, third-port pins 6 and 7 detach.
// R17: With the SPI off, the serial pins are plain I/O under dir and latch.
module ppio_top #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [WIDTH-1:0] second_port_pin_i,
  output wire [WIDTH-1:0] second_port_pin_o,
  output wire [WIDTH-1:0] second_port_oe_n_o,
  output wire [WIDTH-1:0] second_port_pullup_o,
  input wire [WIDTH-1:0] third_port_pin_i,
  output wire [WIDTH-1:0] third_port_pin_o,
  output wire [WIDTH-1:0] third_port_oe_n_o,
  output wire [WIDTH-1:0] third_port_pullup_o,
  output reg spi_slave_active_o,
  output reg comparator_negative_input_o,
  output reg comparator_positive_input_o,
  output reg [1:0] comparator_buffer_off_o,
  output reg counter_one_count_source_o,
  output reg counter_zero_count_source_o,
  output reg crystal_on_pins_o
);

  // --------------------------------------------------------------------
  // Address decode.
  // --------------------------------------------------------------------
  function hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      hit = (adr == {idx, 2'b00});
    end
  endfunction

  reg [WIDTH-1:0] second_port_latch;
  reg [WIDTH-1:0] second_port_direction;
  reg [WIDTH-1:0] third_port_latch;
  reg [WIDTH-1:0] third_port_direction;
  reg [3:0] ctrl;

  wire [WIDTH-1:0] second_sync;
  wire [WIDTH-1:0] third_sync;
  wire [WIDTH-1:0] second_force_in;
  wire [WIDTH-1:0] third_detach;
  wire [WIDTH-1:0] second_port_pin_sample;
  wire [WIDTH-1:0] third_port_pin_sample;
  wire spi_en;
  wire spi_master;
  wire spi_slave;
  wire power_down;
  wire timer_two_async_select;
  wire access;
  wire wr_lane;
  wire next_cmp_neg_routed;
  wire next_cmp_pos_routed;
  reg [31:0] next_rdata;

  assign spi_en = ctrl[`PPIO_CTRL_SPI_EN];
  assign spi_master = spi_en & ctrl[`PPIO_CTRL_SPI_MASTER];
  assign spi_slave = spi_en & ~ctrl[`PPIO_CTRL_SPI_MASTER];
  assign power_down = ctrl[`PPIO_CTRL_POWER_DOWN];
  assign timer_two_async_select = ctrl[`PPIO_CTRL_TIMER_TWO_ASYNC];
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane = access & wb_we_i & wb_sel_i[0];

  // --------------------------------------------------------------------
  // Pin input synchronisers.
  // --------------------------------------------------------------------
  ppio_sync #(
    .WIDTH(WIDTH)
  ) u_second_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(second_port_pin_i),
    .sync_o(second_sync)
  ); // [R10]

  ppio_sync #(
    .WIDTH(WIDTH)
  ) u_third_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(third_port_pin_i),
    .sync_o(third_sync)
  ); // [R10]

  // --------------------------------------------------------------------
  // Direction overrides of the second port and pin detach of the third port.
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_force
      if (g == `PPIO_PB_SCK || g == `PPIO_PB_MOSI ||
          g == `PPIO_PB_SEL) begin : g_slave_in
        assign second_force_in[g] = spi_slave; // [R01] [R03] [R04] [R17]
      end else if (g == `PPIO_PB_MISO) begin : g_master_in
        assign second_force_in[g] = spi_master; // [R02] [R17]
      end else begin : g_plain
        assign second_force_in[g] = 1'b0;
      end
      if (g >= 6) begin : g_xtal
        assign third_detach[g] = timer_two_async_select; // [R16]
      end else begin : g_io
        assign third_detach[g] = 1'b0;
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin drivers.
  // --------------------------------------------------------------------
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pins
      ppio_pin_cell u_second (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dir_i(second_port_direction[g]),
        .latch_i(second_port_latch[g]),
        .force_in_i(second_force_in[g]),
        .detach_i(1'b0),
        .pin_o(second_port_pin_o[g]),
        .oe_n_o(second_port_oe_n_o[g]),
        .pullup_o(second_port_pullup_o[g])
      ); // [R06] [R15]
      ppio_pin_cell u_third (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dir_i(third_port_direction[g]),
        .latch_i(third_port_latch[g]),
        .force_in_i(1'b0),
        .detach_i(third_detach[g]),
        .pin_o(third_port_pin_o[g]),
        .oe_n_o(third_port_oe_n_o[g]),
        .pullup_o(third_port_pullup_o[g])
      ); // [R13] [R14] [R15] [R16]
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin samples as seen by software.
  // --------------------------------------------------------------------
  assign second_port_pin_sample = second_sync &
    ~({{(WIDTH-4){1'b0}}, power_down, power_down, 2'b00}); // [R08]
  assign third_port_pin_sample = third_sync & ~third_detach; // [R12] [R16]

  assign next_cmp_neg_routed = ~second_port_direction[`PPIO_PB_CMP_NEG] &
    ~second_port_latch[`PPIO_PB_CMP_NEG]; // [R07]
  assign next_cmp_pos_routed = ~second_port_direction[`PPIO_PB_CMP_POS] &
    ~second_port_latch[`PPIO_PB_CMP_POS]; // [R07]

  // --------------------------------------------------------------------
  // Alternate-function outputs.
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      spi_slave_active_o <= 1'b0;
      comparator_negative_input_o <= 1'b0;
      comparator_positive_input_o <= 1'b0;
      comparator_buffer_off_o <= 2'b00;
      counter_one_count_source_o <= 1'b0;
      counter_zero_count_source_o <= 1'b0;
      crystal_on_pins_o <= 1'b0;
    end else begin
      spi_slave_active_o <= spi_slave & ~second_sync[`PPIO_PB_SEL]; // [R05]
      comparator_negative_input_o <= next_cmp_neg_routed &
        second_sync[`PPIO_PB_CMP_NEG]; // [R07]
      comparator_positive_input_o <= next_cmp_pos_routed &
        second_sync[`PPIO_PB_CMP_POS]; // [R07]
      comparator_buffer_off_o <= {power_down, power_down}; // [R08]
      counter_one_count_source_o <= second_sync[`PPIO_PB_CNT_ONE]; // [R09]
      counter_zero_count_source_o <= second_sync[`PPIO_PB_CNT_ZERO]; // [R09]
      crystal_on_pins_o <= timer_two_async_select; // [R16]
    end
  end

  // --------------------------------------------------------------------
  // Register writes.
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      second_port_latch <= `PPIO_RST_PORT;
      second_port_direction <= `PPIO_RST_PORT;
      third_port_latch <= `PPIO_RST_PORT;
      third_port_direction <= `PPIO_RST_PORT;
      ctrl <= `PPIO_RST_CTRL;
    end else if (wr_lane) begin
      if (hit(wb_adr_i, `PPIO_IDX_PB_LATCH)) begin
        second_port_latch <= wb_dat_i[WIDTH-1:0];
      end
      if (hit(wb_adr_i, `PPIO_IDX_PB_DIR)) begin
        second_port_direction <= wb_dat_i[WIDTH-1:0];
      end
      if (hit(wb_adr_i, `PPIO_IDX_PC_LATCH)) begin
        third_port_latch <= wb_dat_i[WIDTH-1:0]; // [R11]
      end
      if (hit(wb_adr_i, `PPIO_IDX_PC_DIR)) begin
        third_port_direction <= wb_dat_i[WIDTH-1:0]; // [R11]
      end
      if (hit(wb_adr_i, `PPIO_IDX_CTRL)) begin
        ctrl <= wb_dat_i[3:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux and acknowledge.
  // --------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(wb_adr_i, `PPIO_IDX_PB_LATCH)) begin
      next_rdata[WIDTH-1:0] = second_port_latch;
    end else if (hit(wb_adr_i, `PPIO_IDX_PB_DIR)) begin
      next_rdata[WIDTH-1:0] = second_port_direction;
    end else if (hit(wb_adr_i, `PPIO_IDX_PB_PIN)) begin
      next_rdata[WIDTH-1:0] = second_port_pin_sample;
    end else if (hit(wb_adr_i, `PPIO_IDX_PC_LATCH)) begin
      next_rdata[WIDTH-1:0] = third_port_latch; // [R12]
    end else if (hit(wb_adr_i, `PPIO_IDX_PC_DIR)) begin
      next_rdata[WIDTH-1:0] = third_port_direction; // [R11]
    end else if (hit(wb_adr_i, `PPIO_IDX_PC_PIN)) begin
      next_rdata[WIDTH-1:0] = third_port_pin_sample; // [R12]
    end else if (hit(wb_adr_i, `PPIO_IDX_CTRL)) begin
      next_rdata[3:0] = ctrl;
    end else if (hit(wb_adr_i, `PPIO_IDX_STATUS)) begin
      next_rdata[`PPIO_STAT_SPI_SLAVE_ACTIVE] = spi_slave_active_o;
      next_rdata[`PPIO_STAT_CMP_NEG_ROUTED] = next_cmp_neg_routed;
      next_rdata[`PPIO_STAT_CMP_POS_ROUTED] = next_cmp_pos_routed;
      next_rdata[`PPIO_STAT_XTAL_ON_PINS] = crystal_on_pins_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule // ppio_top

/* sim/ppio_board.sv */
module ppio_board (
  input wire clk_i,
  input wire [7:0] drv_en_i,
  input wire [7:0] drv_val_i,
  input wire [7:0] dev_pin_i,
  input wire [7:0] dev_oe_n_i,
  input wire [7:0] dev_pullup_i,
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;
  always @(posedge clk_i) tog <= ~tog;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (!dev_oe_n_i[k]) level_o[k] = dev_pin_i[k];
      else if (drv_en_i[k]) level_o[k] = drv_val_i[k];
      else if (dev_pullup_i[k]) level_o[k] = 1'b1;
      else level_o[k] = tog;
    end
  end
endmodule // ppio_board

/* sim/ppio_top_assertions.sv */
module ppio_top_assertions #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [WIDTH-1:0] second_port_pin_i,
  input wire [WIDTH-1:0] second_port_oe_n_o,
  input wire [WIDTH-1:0] third_port_oe_n_o,
  input wire [WIDTH-1:0] third_port_pullup_o,
  input wire spi_slave_active_o,
  input wire comparator_negative_input_o,
  input wire [1:0] comparator_buffer_off_o,
  input wire counter_one_count_source_o,
  input wire counter_zero_count_source_o,
  input wire crystal_on_pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] up_cnt;
  wire settled = &up_cnt;
  always @(posedge clk_i) begin
    if (rst_i) up_cnt <= 3'h0;
    else if (!settled) up_cnt <= up_cnt + 3'h1;
  end
  logic started = 1'b0;
  always @(posedge clk_i) started <= 1'b1;
  property p_rst_tri;
    disable iff (1'b0) started && rst_i |->
      &second_port_oe_n_o && &third_port_oe_n_o;
  endproperty
  a_rst_tri: assert property (p_rst_tri)
    else $error("pins driven in reset");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_pu_drv;
    ~|(third_port_pullup_o & ~third_port_oe_n_o);
  endproperty
  a_pu_drv: assert property (p_pu_drv)
    else $error("pullup on output");
  property p_xtal;
    crystal_on_pins_o && $past(crystal_on_pins_o) |->
      third_port_oe_n_o[7:6] == 2'b11 && third_port_pullup_o[7:6] == 2'b00;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins used");
  property p_buf;
    comparator_buffer_off_o[0] == comparator_buffer_off_o[1];
  endproperty
  a_buf: assert property (p_buf) else $error("buffer off split");
  property p_cnt0;
    settled |-> counter_zero_count_source_o == $past(second_port_pin_i[0], 3);
  endproperty
  a_cnt0: assert property (p_cnt0) else $error("count zero source");
  property p_cnt1;
    settled |-> counter_one_count_source_o == $past(second_port_pin_i[1], 3);
  endproperty
  a_cnt1: assert property (p_cnt1)
    else $error("count one source");
  property p_neg;
    settled && comparator_negative_input_o |-> $past(second_port_pin_i[3], 3);
  endproperty
  a_neg: assert property (p_neg) else $error("negative input");
  property p_sel;
    settled && spi_slave_active_o |-> !$past(second_port_pin_i[4], 3);
  endproperty
  a_sel: assert property (p_sel) else $error("slave not selected");
  property p_slv;
    spi_slave_active_o && $past(spi_slave_active_o) |->
      second_port_oe_n_o[7] && second_port_oe_n_o[5] && second_port_oe_n_o[4];
  endproperty
  a_slv: assert property (p_slv)
    else $error("slave pin driven");
  c_slv: cover property (spi_slave_active_o);
  c_xtal: cover property (crystal_on_pins_o);
  c_buf: cover property (comparator_buffer_off_o[0]);
endmodule // ppio_top_assertions

/* sim/ppio_top_tb_top.sv */
module ppio_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 8'h00, b_en = 8'h1f, b_val = 8'h0d;
  logic [7:0] c_en = 8'h30, c_val = 8'h20;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  wire [7:0] b_i, b_o, b_oe, b_pu, c_i, c_o, c_oe, c_pu;
  wire [1:0] boff;
  wire act, neg, pos, cnt1, cnt0, xtal;
  int n_mismatch = 0, cmp_count = 0;
  logic [7:0] t_ctl [3] = '{8'h01, 8'h03, 8'h00};
  logic [7:0] t_oe [3] = '{8'hbf, 8'h4f, 8'h0f};
  logic [7:0] t_pu [3] = '{8'hb0, 8'h40, 8'h00};
  always #2 clk = ~clk;
  ppio_top u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .second_port_pin_i(b_i),
    .second_port_pin_o(b_o), .second_port_oe_n_o(b_oe),
    .second_port_pullup_o(b_pu), .third_port_pin_i(c_i),
    .third_port_pin_o(c_o), .third_port_oe_n_o(c_oe),
    .third_port_pullup_o(c_pu), .spi_slave_active_o(act),
    .comparator_negative_input_o(neg), .comparator_positive_input_o(pos),
    .comparator_buffer_off_o(boff), .counter_one_count_source_o(cnt1),
    .counter_zero_count_source_o(cnt0), .crystal_on_pins_o(xtal));
  ppio_board u_bb (.clk_i(clk), .drv_en_i(b_en), .drv_val_i(b_val),
    .dev_pin_i(b_o), .dev_oe_n_i(b_oe), .dev_pullup_i(b_pu), .level_o(b_i));
  ppio_board u_bc (.clk_i(clk), .drv_en_i(c_en), .drv_val_i(c_val),
    .dev_pin_i(c_o), .dev_oe_n_i(c_oe), .dev_pullup_i(c_pu), .level_o(c_i));
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hf};
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic st();
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc("c_dir", 8'h50, 8'h00);
    rc("c_lat", 8'h54, 8'h00);
    wr(8'h50, 8'hcf);
    wr(8'h54, 8'hb5);
    rc("c_lat", 8'h54, 8'hb5);
    rc("c_dir", 8'h50, 8'hcf);
    st();
    chk("c_o", c_o, 8'h85);
    chk("c_oe", c_oe, 8'h30);
    chk("c_pu", c_pu, 8'h30);
    rc("c_pin", 8'h4c, 8'ha5);
    wr(8'h4c, 8'hff);
    rc("c_pin_ro", 8'h4c, 8'ha5);
    rc("unmapped", 8'hfc, 8'h00);
    wr(8'h80, 8'h08);
    st();
    chk("x_oe", c_oe, 8'hf0);
    chk("xtal", xtal, 1'b1);
    rc("x_stat", 8'h84, 8'h0e);
    rc("x_pin", 8'h4c, 8'h25);
    wr(8'h80, 8'h00);
    wr(8'h5c, 8'hf0);
    wr(8'h60, 8'hf0);
    rc("b_lat", 8'h60, 8'hf0);
    rc("b_dir", 8'h5c, 8'hf0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h80, t_ctl[i]);
      st();
      chk("b_oe", b_oe, t_oe[i]);
      chk("b_pu", b_pu, t_pu[i]);
      chk("act", act, i == 0);
      chk("b_o", b_o, 8'hf0 & ~t_oe[i]);
      rc("stat", 8'h84, 8'h06 | 8'(i == 0));
    end
    wr(8'h80, 8'h01);
    b_en <= 8'h0f;
    st();
    chk("act_off", act, 1'b0);
    chk("alt", {neg, pos, cnt1, cnt0}, 4'hd);
    rc("ctrl", 8'h80, 8'h01);
    wr(8'h80, 8'h04);
    st();
    chk("boff", boff, 2'b11);
    chk("neg_pd", neg, 1'b1);
    bus(1'b0, 8'h58, 8'h00);
    chk("pd_pin", q & 32'h0f, 32'h01);
    wr(8'h60, 8'hf8);
    st();
    chk("neg_off", neg, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    #1;
    chk("rst_oe", {b_oe, c_oe}, 16'hffff);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc("c_lat_rst", 8'h54, 8'h00);
    test_done();
  end
endmodule // ppio_top_tb_top

bind ppio_top ppio_top_assertions #(.WIDTH(WIDTH)) u_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .second_port_pin_i, .second_port_oe_n_o,
  .third_port_oe_n_o, .third_port_pullup_o, .spi_slave_active_o,
  .comparator_negative_input_o, .comparator_buffer_off_o,
  .counter_one_count_source_o, .counter_zero_count_source_o,
  .crystal_on_pins_o);
